// ---- verilog/arie_defines.svh ----
// Register offsets, field positions and reset values of the receive interrupt enable block
`ifndef ARIE_DEFINES_SVH
`define ARIE_DEFINES_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define ARIE_OFS_ENABLE 12'h000
`define ARIE_OFS_FLAGS 12'h004
`define ARIE_OFS_RXCOUNT 12'h008

// ****************************************
// Enable register field positions
// ****************************************
`define ARIE_EN_OVERRUN 0
`define ARIE_EN_SYNC 1
`define ARIE_EN_CKFAIL 2
`define ARIE_EN_DMA 3
`define ARIE_EN_LAST 4
`define ARIE_EN_DATA 5
`define ARIE_EN_FRAME 7

// ****************************************
// Event flag register field positions
// ****************************************
`define ARIE_FL_OVERRUN 0
`define ARIE_FL_SYNC 1
`define ARIE_FL_CKFAIL 2
`define ARIE_FL_SLOT 3
`define ARIE_FL_LAST 4
`define ARIE_FL_DATA 5
`define ARIE_FL_FRAME 6
`define ARIE_FL_DMA 7
`define ARIE_FL_ERR 8

// ****************************************
// Reset values and widths
// ****************************************
`define ARIE_ENABLE_RST 8'h00
`define ARIE_RXCOUNT_RST 5'h01
`define ARIE_RXCOUNT_W 5
`define ARIE_NSRC 7

`endif

// ---- verilog/arie_pkg.sv ----
// Types shared by the receive interrupt enable block
`default_nettype none
package arie_pkg;

   // APB request as seen by the slave
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } arie_apb_req_t;

   // Register write strobe with its address and data
   typedef struct packed {
      logic stb;
      logic [11:0] addr;
      logic [31:0] data;
   } arie_wr_t;

   // Receiver conditions, overrun in bit 0
   typedef struct packed {
      logic frame_start;
      logic data_ready;
      logic final_slot;
      logic dma_fault;
      logic clock_fail;
      logic unexpected_sync;
      logic overrun;
   } arie_src_t;

endpackage
`default_nettype wire

// ---- verilog/arie_event_flags.sv ----
// Bank of sticky receiver event flags, set by hardware, cleared by software
`default_nettype none
`include "arie_defines.svh"
module arie_event_flags (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Set and clear requests
   input wire arie_pkg::arie_src_t set_i,
   input wire arie_pkg::arie_src_t clr_i,
   // Flag state
   output arie_pkg::arie_src_t flags_q
);

   logic [`ARIE_NSRC-1:0] flg_d;

   genvar gi;
   generate
      for (gi = 0; gi < `ARIE_NSRC; gi++) begin : g_flag
         // Set outranks clear so a late event is never lost
         always_comb begin
            flg_d[gi] = set_i[gi] | (flags_q[gi] & ~clr_i[gi]);
         end

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               flags_q[gi] <= 1'b0;
            end else begin
               flags_q[gi] <= flg_d[gi];
            end
         end
      end
   endgenerate

endmodule
`default_nettype wire

// ---- verilog/arie_apb_slave.sv ----
// APB slave front end: zero wait, registered read data, error on unmapped offsets
`default_nettype none
`include "arie_defines.svh"
module arie_apb_slave (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB request
   input wire arie_pkg::arie_apb_req_t req_i,
   // APB answer
   output logic pready,
   output logic pslverr,
   output logic [31:0] prdata,
   // Register side
   input wire logic [31:0] rd_word_i,
   output logic [11:0] rd_addr_o,
   output arie_pkg::arie_wr_t wr_o,
   output logic rd_done_o
);

   logic hit;
   logic setup;
   logic access;
   logic [31:0] prdata_d;
   logic [31:0] prdata_q;

   // Decode the three word offsets; anything else answers with an error
   always_comb begin
      hit = (req_i.paddr == `ARIE_OFS_ENABLE) || (req_i.paddr == `ARIE_OFS_FLAGS) ||
            (req_i.paddr == `ARIE_OFS_RXCOUNT);
      setup = req_i.psel & ~req_i.penable;
      access = req_i.psel & req_i.penable;
      rd_addr_o = req_i.paddr;
      wr_o.stb = access & req_i.pwrite & hit;
      wr_o.addr = req_i.paddr;
      wr_o.data = req_i.pwdata;
      rd_done_o = access & ~req_i.pwrite & hit;
      pready = access;
      pslverr = access & ~hit;
      prdata = prdata_q;
   end

   // Read word is caught in the setup cycle so prdata comes from a flop
   always_comb begin
      prdata_d = prdata_q;
      if (setup) begin
         prdata_d = (hit && !req_i.pwrite) ? rd_word_i : 32'h0000_0000;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0000_0000;
      end else begin
         prdata_q <= prdata_d;
      end
   end

endmodule
`default_nettype wire

// ---- verilog/arie_rx_irq.sv ----
// Receive interrupt enable, event flags and interrupt combining of the audio serial port
//
// The implementer's own choices: the address map and the APB interface to the registers.
`default_nettype none
`include "arie_defines.svh"
module arie_rx_irq (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,

   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic pslverr,
   output logic [31:0] prdata,

   // Receiver conditions, one-cycle pulses on pclk
   input wire logic rx_frame_start,
   input wire logic rx_data_ready,
   input wire logic rx_clock_fail,
   input wire logic rx_unexpected_sync,
   input wire logic rx_overrun,

   // Slot context from the receive frame logic
   input wire logic rx_slot_start,
   input wire logic rx_slot_last,
   input wire logic rx_slot_odd,

   // Data port read by processor or DMA, one pulse per serializer read
   input wire logic rx_port_read,

   // Interrupt toward the host interrupt controller
   output logic receive_irq
);

   // ****************************************
   // Declarations
   // ****************************************
   arie_pkg::arie_apb_req_t apb_req;
   arie_pkg::arie_wr_t wr;
   logic [11:0] rd_addr;
   logic [31:0] rd_word;
   logic rd_done;

   logic en_wr;
   logic flag_wr;
   logic cnt_wr;

   logic [7:0] enable_d;
   logic [7:0] enable_q;
   logic [`ARIE_RXCOUNT_W-1:0] rxcount_d;
   logic [`ARIE_RXCOUNT_W-1:0] rxcount_q;

   logic [`ARIE_RXCOUNT_W-1:0] reads_d;
   logic [`ARIE_RXCOUNT_W-1:0] reads_q;
   logic dma_fault_evt;

   arie_pkg::arie_src_t set_vec;
   arie_pkg::arie_src_t clr_vec;
   arie_pkg::arie_src_t flags_q;
   arie_pkg::arie_src_t en_vec;
   arie_pkg::arie_src_t pend_vec;
   logic any_err;

   logic irq_d;
   logic irq_q;

   // ****************************************
   // Bus front end
   // ****************************************

   // Pack the bus pins for the slave
   always_comb begin
      apb_req.psel = psel;
      apb_req.penable = penable;
      apb_req.pwrite = pwrite;
      apb_req.paddr = paddr;
      apb_req.pwdata = pwdata;
   end

   arie_apb_slave u_apb (
      .pclk(pclk),
      .presetn(presetn),
      .req_i(apb_req),
      .pready(pready),
      .pslverr(pslverr),
      .prdata(prdata),
      .rd_word_i(rd_word),
      .rd_addr_o(rd_addr),
      .wr_o(wr),
      .rd_done_o(rd_done)
   );

   // ****************************************
   // Write decode
   // ****************************************

   // One strobe per register; unmapped offsets never strobe,
   // so a stray address cannot clobber a neighbouring register
   always_comb begin
      en_wr = wr.stb && (wr.addr == `ARIE_OFS_ENABLE);
      flag_wr = wr.stb && (wr.addr == `ARIE_OFS_FLAGS);
      cnt_wr = wr.stb && (wr.addr == `ARIE_OFS_RXCOUNT);
   end

   // ****************************************
   // Enable register
   // ****************************************

   // Only the seven defined enable bits are kept; the rest never store
   always_comb begin
      enable_d = enable_q;
      if (en_wr) begin
         enable_d = `ARIE_ENABLE_RST;
         enable_d[`ARIE_EN_FRAME] = wr.data[`ARIE_EN_FRAME];
         enable_d[`ARIE_EN_DATA] = wr.data[`ARIE_EN_DATA];
         enable_d[`ARIE_EN_LAST] = wr.data[`ARIE_EN_LAST];
         enable_d[`ARIE_EN_DMA] = wr.data[`ARIE_EN_DMA];
         enable_d[`ARIE_EN_CKFAIL] = wr.data[`ARIE_EN_CKFAIL];
         enable_d[`ARIE_EN_SYNC] = wr.data[`ARIE_EN_SYNC];
         enable_d[`ARIE_EN_OVERRUN] = wr.data[`ARIE_EN_OVERRUN];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         enable_q <= `ARIE_ENABLE_RST;
      end else begin
         enable_q <= enable_d;
      end
   end

   // ****************************************
   // Receiver count register
   // ****************************************

   // Number of serializers set up as receivers, the per-slot read budget
   always_comb begin
      rxcount_d = rxcount_q;
      if (cnt_wr) begin
         rxcount_d = wr.data[`ARIE_RXCOUNT_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rxcount_q <= `ARIE_RXCOUNT_RST;
      end else begin
         rxcount_q <= rxcount_d;
      end
   end

   // ****************************************
   // Data port read counter
   // ****************************************

   // Reads in the current slot; a read past the budget is a DMA fault.
   // A slot start in the same cycle as a read counts that read as the first.
   always_comb begin
      reads_d = reads_q;
      dma_fault_evt = 1'b0;
      if (rx_slot_start) begin
         reads_d = '0;
      end
      if (rx_port_read) begin
         if (reads_d >= rxcount_q) begin
            dma_fault_evt = 1'b1;
         end else begin
            reads_d = reads_d + `ARIE_RXCOUNT_W'(1);
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reads_q <= '0;
      end else begin
         reads_q <= reads_d;
      end
   end

   // ****************************************
   // Event flags
   // ****************************************

   // Hardware set requests per source
   always_comb begin
      set_vec.frame_start = rx_frame_start;
      set_vec.data_ready = rx_data_ready;
      set_vec.final_slot = rx_data_ready & rx_slot_last;
      set_vec.dma_fault = dma_fault_evt;
      set_vec.clock_fail = rx_clock_fail;
      set_vec.unexpected_sync = rx_unexpected_sync;
      set_vec.overrun = rx_overrun;
   end

   // Write-one-to-clear; zeros leave a flag alone
   always_comb begin
      clr_vec = '0;
      if (flag_wr) begin
         clr_vec.frame_start = wr.data[`ARIE_FL_FRAME];
         clr_vec.data_ready = wr.data[`ARIE_FL_DATA];
         clr_vec.final_slot = wr.data[`ARIE_FL_LAST];
         clr_vec.dma_fault = wr.data[`ARIE_FL_DMA];
         clr_vec.clock_fail = wr.data[`ARIE_FL_CKFAIL];
         clr_vec.unexpected_sync = wr.data[`ARIE_FL_SYNC];
         clr_vec.overrun = wr.data[`ARIE_FL_OVERRUN];
      end
   end

   arie_event_flags u_flags (
      .pclk(pclk),
      .presetn(presetn),
      .set_i(set_vec),
      .clr_i(clr_vec),
      .flags_q(flags_q)
   );

   // ****************************************
   // Interrupt combining
   // ****************************************

   // Enable bits gathered into source order; the two registers differ in layout
   always_comb begin
      en_vec.frame_start = enable_q[`ARIE_EN_FRAME];
      en_vec.data_ready = enable_q[`ARIE_EN_DATA];
      en_vec.final_slot = enable_q[`ARIE_EN_LAST];
      en_vec.dma_fault = enable_q[`ARIE_EN_DMA];
      en_vec.clock_fail = enable_q[`ARIE_EN_CKFAIL];
      en_vec.unexpected_sync = enable_q[`ARIE_EN_SYNC];
      en_vec.overrun = enable_q[`ARIE_EN_OVERRUN];
   end

   // Each source pends while its flag and its enable are both one;
   // the level falls only when software clears the flag or the enable
   genvar gs;
   generate
      for (gs = 0; gs < `ARIE_NSRC; gs++) begin : g_pend
         always_comb begin
            pend_vec[gs] = flags_q[gs] & en_vec[gs];
         end
      end
   endgenerate

   // Level output; registered so the controller sees a glitch-free line
   always_comb begin
      irq_d = |pend_vec;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= irq_d;
      end
   end

   assign receive_irq = irq_q;

   // ****************************************
   // Read data
   // ****************************************

   // Summary of the four error flags for a single-bit check
   always_comb begin
      any_err = flags_q.overrun | flags_q.unexpected_sync | flags_q.clock_fail | flags_q.dma_fault;
   end

   // Unused and reserved bits read as zero
   always_comb begin
      rd_word = 32'h0000_0000;
      unique case (rd_addr)
         `ARIE_OFS_ENABLE: begin
            rd_word[7:0] = enable_q;
         end
         `ARIE_OFS_FLAGS: begin
            rd_word[`ARIE_FL_FRAME] = flags_q.frame_start;
            rd_word[`ARIE_FL_DATA] = flags_q.data_ready;
            rd_word[`ARIE_FL_LAST] = flags_q.final_slot;
            rd_word[`ARIE_FL_DMA] = flags_q.dma_fault;
            rd_word[`ARIE_FL_CKFAIL] = flags_q.clock_fail;
            rd_word[`ARIE_FL_SYNC] = flags_q.unexpected_sync;
            rd_word[`ARIE_FL_OVERRUN] = flags_q.overrun;
            rd_word[`ARIE_FL_SLOT] = rx_slot_odd;
            rd_word[`ARIE_FL_ERR] = any_err;
         end
         `ARIE_OFS_RXCOUNT: begin
            rd_word[`ARIE_RXCOUNT_W-1:0] = rxcount_q;
         end
         default: begin
            rd_word = 32'h0000_0000;
         end
      endcase
   end

   // Reads have no side effect; flags clear only by writing ones
   logic unused_rd;
   assign unused_rd = rd_done;

endmodule
`default_nettype wire

// ---- tb/arie_rx_irq_chk.sv ----
// Assertion checker for the receive interrupt enable block
`default_nettype none
module arie_rx_irq_chk (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [31:0] prdata,
   // Receiver side and interrupt
   input wire logic rx_frame_start,
   input wire logic rx_data_ready,
   input wire logic rx_clock_fail,
   input wire logic rx_unexpected_sync,
   input wire logic rx_overrun,
   input wire logic rx_slot_last,
   input wire logic rx_port_read,
   input wire logic receive_irq
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] en_q;
   logic [7:0] en_d;
   logic wr;
   logic ev;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // Any cause that may lift the interrupt two edges later
   assign wr = psel && penable && pwrite;
   assign ev = rx_frame_start || rx_data_ready || rx_clock_fail || rx_unexpected_sync || rx_overrun || rx_port_read;
   // Shadow enable, bit 6 never sticks
   always_comb begin
      en_d = en_q;
      if (wr && paddr == 12'h000) begin
         en_d = pwdata[7:0] & 8'hbf;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_q <= 8'h00;
      end else begin
         en_q <= en_d;
      end
   end
   // ****************************************
   // Properties
   // ****************************************
   a_enable_read: assert property (psel && penable && !pwrite && paddr == 12'h000 |-> prdata == {24'h0, en_q})
      else $error("enable readback wrong");
   a_quiet_masked: assert property (en_q == 8'h00 && $past(en_q) == 8'h00 |-> !receive_irq)
      else $error("interrupt with all enables off");
   a_err_irq: assert property ((rx_overrun && en_q[0] || rx_unexpected_sync && en_q[1] ||
      rx_clock_fail && en_q[2]) |-> ##2 receive_irq)
      else $error("enabled error event gave no interrupt");
   a_slot_irq: assert property ((rx_frame_start && en_q[7] || rx_data_ready && (en_q[5] ||
      rx_slot_last && en_q[4])) |-> ##2 receive_irq)
      else $error("enabled slot event gave no interrupt");
   a_rise_cause: assert property ($rose(receive_irq) |-> $past(wr, 2) || $past(ev, 2))
      else $error("interrupt rose without cause");
   a_fall_cause: assert property ($fell(receive_irq) |-> $past(wr, 2))
      else $error("interrupt fell without a write");
   a_irq_stays: assert property (receive_irq && !wr && !$past(wr) |=> receive_irq)
      else $error("interrupt dropped on its own");
   a_set_wins: assert property (wr && paddr == 12'h004 && pwdata[0] && rx_overrun && en_q[0]
      |-> ##2 receive_irq [*3])
      else $error("clear beat a same cycle event");
   a_unmapped_err: assert property (psel && penable && paddr > 12'h008 |-> pready && pslverr)
      else $error("unmapped access not refused");
   // Main scenarios reached
   c_rise: cover property ($rose(receive_irq));
   c_fall: cover property ($fell(receive_irq));
   c_set_wins: cover property (wr && paddr == 12'h004 && rx_overrun && en_q[0]);
endmodule
bind arie_rx_irq arie_rx_irq_chk i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
   .rx_frame_start(rx_frame_start), .rx_data_ready(rx_data_ready), .rx_clock_fail(rx_clock_fail),
   .rx_unexpected_sync(rx_unexpected_sync), .rx_overrun(rx_overrun), .rx_slot_last(rx_slot_last),
   .rx_port_read(rx_port_read), .receive_irq(receive_irq));
`default_nettype wire

// ---- tb/arie_host_pic.sv ----
// Host interrupt controller model counting receive interrupt requests
`default_nettype none
module arie_host_pic (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Level request in, request count out
   input wire logic receive_irq,
   output logic [7:0] irq_count
);
   timeunit 1ns;
   timeprecision 1ps;
   logic seen_q;
   // Level input, so only a new assertion counts as a request
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seen_q <= 1'b0;
         irq_count <= 8'h00;
      end else begin
         seen_q <= receive_irq;
         irq_count <= irq_count + {7'h0, receive_irq && !seen_q};
      end
   end
endmodule
`default_nettype wire

// ---- tb/audio_rx_interrupt_enable_test.sv ----
// Testbench of the receive interrupt enable block
`default_nettype none
module audio_rx_interrupt_enable_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [7:0] ev = 8'h00;
   logic pready;
   logic pslverr;
   logic [31:0] prdata;
   logic receive_irq;
   logic [7:0] irq_count;
   logic [31:0] rd;
   logic er;
   int err_total = 0;
   int num_checks = 0;
   // Per source: enable, first and second event cycle, disabled enable, expected flags
   logic [7:0] en_tab [7] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h80};
   logic [7:0] e1_tab [7] = '{8'h08, 8'h10, 8'h20, 8'h03, 8'h44, 8'h40, 8'h80};
   logic [7:0] e2_tab [7] = '{8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00};
   logic [7:0] ng_tab [7] = '{8'hbe, 8'hbd, 8'hbb, 8'hb7, 8'h8f, 8'h9f, 8'h3f};
   logic [8:0] fl_tab [7] = '{9'h101, 9'h102, 9'h104, 9'h180, 9'h030, 9'h020, 9'h040};
   always #5 pclk = ~pclk;
   // Slot parity not under test, tied low
   arie_rx_irq i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
      .rx_frame_start(ev[7]), .rx_data_ready(ev[6]), .rx_clock_fail(ev[5]), .rx_unexpected_sync(ev[4]),
      .rx_overrun(ev[3]), .rx_slot_start(ev[0]), .rx_slot_last(ev[2]), .rx_slot_odd(1'b0),
      .rx_port_read(ev[1]), .receive_irq(receive_irq));
   arie_host_pic i_pic (.pclk(pclk), .presetn(presetn), .receive_irq(receive_irq), .irq_count(irq_count));
   // ****************************************
   // Tasks
   // ****************************************
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // APB transfer; events in e ride along with the access phase, then one idle cycle
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [7:0] e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      ev <= e;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      ev <= 8'h00;
      @(posedge pclk);
   endtask
   task automatic fire(input logic [7:0] a, input logic [7:0] b);
      ev <= a;
      @(posedge pclk);
      ev <= b;
      @(posedge pclk);
      ev <= 8'h00;
      repeat (2) @(posedge pclk);
   endtask
   task automatic tally_and_finish();
      if (err_total == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // Hang guard, far beyond the few hundred cycles the tests take
   initial begin
      #100000;
      err_total++;
      tally_and_finish();
   end
   // ****************************************
   // Tests
   // ****************************************
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, 12'h000, 32'h0, 8'h00);
      cmp(rd, 32'h0);
      apb(1'b1, 12'h000, 32'hffffffff, 8'h00);
      apb(1'b0, 12'h000, 32'h0, 8'h00);
      cmp(rd, 32'hbf);
      for (int i = 0; i < 7; i++) begin
         apb(1'b1, 12'h000, {24'h0, ng_tab[i]}, 8'h00);
         fire(e1_tab[i], e2_tab[i]);
         cmp({31'h0, receive_irq}, 32'h0);
         apb(1'b1, 12'h004, 32'h1ff, 8'h00);
         apb(1'b1, 12'h000, {24'h0, en_tab[i]}, 8'h00);
         fire(e1_tab[i], e2_tab[i]);
         cmp({31'h0, receive_irq}, 32'h1);
         apb(1'b0, 12'h004, 32'h0, 8'h00);
         cmp(rd, {23'h0, fl_tab[i]});
         apb(1'b1, 12'h004, 32'h0, 8'h00);
         repeat (2) @(posedge pclk);
         cmp({31'h0, receive_irq}, 32'h1);
         apb(1'b1, 12'h004, 32'h1ff, 8'h00);
         repeat (2) @(posedge pclk);
         cmp({31'h0, receive_irq}, 32'h0);
      end
      // Clear and new overrun in the same cycle
      apb(1'b1, 12'h000, 32'h1, 8'h00);
      fire(8'h08, 8'h00);
      apb(1'b1, 12'h004, 32'h1ff, 8'h08);
      repeat (3) @(posedge pclk);
      cmp({31'h0, receive_irq}, 32'h1);
      apb(1'b0, 12'h004, 32'h0, 8'h00);
      cmp(rd, 32'h101);
      apb(1'b1, 12'h004, 32'h1ff, 8'h00);
      repeat (2) @(posedge pclk);
      cmp({31'h0, receive_irq}, 32'h0);
      // Budget of two reads per slot: two reads give no fault
      apb(1'b1, 12'h008, 32'h2, 8'h00);
      apb(1'b0, 12'h008, 32'h0, 8'h00);
      cmp(rd, 32'h2);
      apb(1'b1, 12'h000, 32'h8, 8'h00);
      fire(8'h03, 8'h02);
      cmp({31'h0, receive_irq}, 32'h0);
      apb(1'b0, 12'h00c, 32'h0, 8'h00);
      cmp({31'h0, er}, 32'h1);
      cmp({24'h0, irq_count}, 32'h8);
      tally_and_finish();
   end
endmodule
`default_nettype wire
